// [src/fpcl_cfg.svh]
// Timing, width and count constants of the byte-wide configuration port.
`ifndef FPCL_CFG_SVH
`define FPCL_CFG_SVH
`define FPCL_CLK_PERIOD_NS 8
`define FPCL_POR_TIME_US 45
`define FPCL_DONE_USER_DELAY_NS 60
`define FPCL_STARTUP_CYCLES 3192
`define FPCL_FALL_EDGES 2
`define FPCL_DATA_W 8
`define FPCL_FIFO_DEPTH 8
`define FPCL_STREAM_BYTES 1024
`define FPCL_POR_CYCLES ((`FPCL_POR_TIME_US * 1000 + `FPCL_CLK_PERIOD_NS - 1) / `FPCL_CLK_PERIOD_NS)
`define FPCL_DONE_USER_DELAY_CYCLES ((`FPCL_DONE_USER_DELAY_NS + `FPCL_CLK_PERIOD_NS - 1) / `FPCL_CLK_PERIOD_NS)
`endif

// [src/fpcl_pkg.sv]
// Types shared by the configuration port modules.
package fpcl_pkg;
  typedef enum logic [2:0] {
    st_por,
    st_wait,
    st_load,
    st_tail,
    st_delay,
    st_start,
    st_user,
    st_halt
  } fpcl_state_t;

  typedef struct packed {
    logic request_n;
    logic cclk;
    logic ce_n;
    logic uclk;
    logic status_n;
    logic complete;
    logic [7:0] data;
  } fpcl_pins_t;
endpackage : fpcl_pkg

// [src/fpcl_fifo.sv]
// Flip-flop FIFO that buffers configuration bytes towards the loader.
`timescale 1ns/1ps
`default_nettype none
module fpcl_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk, // System clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic clk_en, // Freezes all state while low.
  input wire logic flush, // Empties the FIFO.
  input wire logic in_valid, // Write request.
  output logic in_ready, // Room for one more word.
  input wire logic [W-1:0] in_data, // Written word.
  output logic out_valid, // A word is waiting.
  input wire logic out_ready, // Reader takes the word.
  output logic [W-1:0] out_data // Oldest word.
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("fpcl_fifo: DEPTH must be a power of two of at least 2");
    end
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;

  assign in_ready = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign push = clk_en && in_valid && in_ready && !flush;
  assign pop = clk_en && out_valid && out_ready && !flush;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (clk_en && flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  default clocking fc @(posedge clk); endclocking
  default disable iff (!nrst);

  a_fifo_no_overrun: assert property ((!in_ready && !flush) |-> ##1 (wr_ptr == $past(wr_ptr)))
    else $error("FIFO pointer moved while full");
endmodule : fpcl_fifo
`default_nettype wire

// [src/fpcl_top.sv]
// Device-side logic of the byte-wide configuration port.
`timescale 1ns/1ps
`default_nettype none
`include "fpcl_cfg.svh"
module fpcl_top
  import fpcl_pkg::*;
#(
  parameter int POR_CYCLES = `FPCL_POR_CYCLES,
  parameter int STREAM_BYTES = `FPCL_STREAM_BYTES,
  parameter int FIFO_DEPTH = `FPCL_FIFO_DEPTH
) (
  input wire logic clk, // System clock, 125 MHz.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic clk_en, // Freezes all state while low.
  input wire logic config_request_n, // Reconfiguration request pin.
  input wire logic config_clock, // Host data clock pin.
  input wire logic [`FPCL_DATA_W-1:0] config_data, // Host data bus pins.
  input wire logic chip_enable_in_n, // Chain enable pin.
  input wire logic user_startup_clock, // Optional start-up clock pin.
  input wire logic use_user_clock, // Start-up counts the user clock.
  input wire logic data0_user_en, // Dual-purpose option for data bit zero.
  input wire logic data0_user_value, // User value for data bit zero.
  input wire logic load_error, // Loader found a bad stream.
  input wire logic config_status_n_in, // Shared status line level.
  output logic config_status_n_out, // Status line drive value.
  output logic config_status_n_oe, // Status line pulled low.
  input wire logic config_complete_in, // Shared complete line level.
  output logic config_complete_out, // Complete line drive value.
  output logic config_complete_oe, // Complete line pulled low.
  input wire logic init_complete_in, // Init-complete line level.
  output logic init_complete_out, // Init-complete drive value.
  output logic init_complete_oe, // Init-complete pulled low.
  output logic chip_enable_out_n, // Enables the next device.
  output logic [`FPCL_DATA_W-1:0] stream_data, // Byte towards the loader.
  output logic stream_valid, // Byte available.
  input wire logic stream_ready, // Loader takes the byte.
  output logic data0_out, // Data bit zero user drive value.
  output logic data0_oe, // Data bit zero driven.
  output logic user_mode, // Device is in user mode.
  output logic weak_pullup_en // Weak pull-ups on user pins.
);
  localparam int BW = $clog2(STREAM_BYTES + 1);
  localparam int PW = $clog2(POR_CYCLES + 1);
  localparam int SW = $clog2(`FPCL_STARTUP_CYCLES + 1);
  localparam logic [BW-1:0] LAST_BYTE = BW'(STREAM_BYTES);
  localparam logic [BW-1:0] EARLY_BYTE = BW'(STREAM_BYTES - 1);
  localparam logic [PW-1:0] POR_LAST = PW'(POR_CYCLES - 1);
  localparam logic [SW-1:0] START_LAST = SW'(`FPCL_STARTUP_CYCLES - 1);
  localparam logic [SW-1:0] DELAY_LAST = SW'(`FPCL_DONE_USER_DELAY_CYCLES - 1);
  localparam logic [1:0] FALL_LAST = 2'(`FPCL_FALL_EDGES - 1);

  initial begin
    if (STREAM_BYTES < 2 || POR_CYCLES < 1 || FIFO_DEPTH < 2) begin
      $error("fpcl_top: STREAM_BYTES and FIFO_DEPTH need 2, POR_CYCLES 1");
    end
  end

  fpcl_pins_t pins_raw;
  fpcl_pins_t sync1;
  fpcl_pins_t sync2;
  fpcl_pins_t prev;
  fpcl_state_t state;
  logic [BW-1:0] byte_cnt;
  logic [PW-1:0] por_cnt;
  logic [SW-1:0] start_cnt;
  logic [1:0] fall_cnt;
  logic own_error;
  logic cclk_rise;
  logic cclk_fall;
  logic uclk_rise;
  logic take_byte;
  logic fifo_ready;
  logic start_tick;

  assign pins_raw = '{
    request_n: config_request_n,
    cclk: config_clock,
    ce_n: chip_enable_in_n,
    uclk: user_startup_clock,
    status_n: config_status_n_in,
    complete: config_complete_in,
    data: config_data
  };

  // Every pin passes two flops; only the second stage and its delayed copy are read.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1 <= '0;
      sync2 <= '0;
      prev <= '0;
    end else if (clk_en) begin
      sync1 <= pins_raw;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  // Data and clock share one synchroniser depth, so the byte stays aligned with its edge.
  assign cclk_rise = sync2.cclk && !prev.cclk;
  assign cclk_fall = !sync2.cclk && prev.cclk;
  assign uclk_rise = sync2.uclk && !prev.uclk;
  assign take_byte = clk_en && state == st_load && cclk_rise && !sync2.ce_n;
  assign start_tick = clk_en && state == st_start && (use_user_clock ? uclk_rise : 1'b1);

  // The host clock cannot be stalled, so a byte arriving at a full FIFO is a load error.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      own_error <= 1'b0;
    end else if (clk_en) begin
      if (state == st_por) begin
        own_error <= 1'b0;
      end else if ((take_byte && !fifo_ready) ||
                   (load_error && (state == st_load || state == st_tail))) begin
        own_error <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= st_por;
    end else if (clk_en) begin
      if (!sync2.request_n) begin
        state <= st_por;
      end else begin
        unique case (state)
          st_por: if (por_cnt == POR_LAST) state <= st_wait;
          st_wait: if (sync2.status_n) state <= st_load;
          st_load: begin
            // halt with the shared status line
            if (own_error || !sync2.status_n) begin
              state <= st_halt;
            end else if (take_byte && byte_cnt == LAST_BYTE - 1'b1) begin
              state <= st_tail;
            end
          end
          st_tail: begin
            if (own_error || !sync2.status_n) begin
              state <= st_halt;
            // two host clock falling edges while shared complete is high
            end else if (sync2.complete && cclk_fall && fall_cnt == FALL_LAST) begin
              state <= st_delay;
            end
          end
          st_delay: if (start_cnt == DELAY_LAST) state <= st_start;
          st_start: if (start_tick && start_cnt == START_LAST) state <= st_user;
          st_user: state <= st_user;
          st_halt: state <= st_halt;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      por_cnt <= '0;
    end else if (clk_en) begin
      if (state == st_por && sync2.request_n && por_cnt != POR_LAST) begin
        por_cnt <= por_cnt + 1'b1;
      end else if (state != st_por || !sync2.request_n) begin
        por_cnt <= '0;
      end
    end
  end

  // counters only advance on clock edges
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      byte_cnt <= '0;
    end else if (clk_en) begin
      if (state == st_por) begin
        byte_cnt <= '0;
      end else if (take_byte && fifo_ready) begin
        byte_cnt <= byte_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fall_cnt <= '0;
    end else if (clk_en) begin
      if (state != st_tail) begin
        fall_cnt <= '0;
      // count only once the shared line is high
      end else if (sync2.complete && cclk_fall) begin
        fall_cnt <= fall_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      start_cnt <= '0;
    end else if (clk_en) begin
      if (state == st_delay) begin
        start_cnt <= (start_cnt == DELAY_LAST) ? '0 : start_cnt + 1'b1;
      end else if (state != st_start) begin
        start_cnt <= '0;
      end else if (start_tick) begin
        start_cnt <= start_cnt + 1'b1;
      end
    end
  end

  // Pin enables are registered from the state, so each leaves a flop; the three line drive values are constant 0.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      config_status_n_oe <= 1'b1;
      config_complete_oe <= 1'b1;
      init_complete_oe <= 1'b1;
      chip_enable_out_n <= 1'b1;
      user_mode <= 1'b0;
      weak_pullup_en <= 1'b1;
      data0_oe <= 1'b0;
      data0_out <= 1'b0;
    end else if (clk_en) begin
      config_status_n_oe <= state == st_por || own_error || !sync2.request_n;
      // held until one byte early
      // The release must stay once the next-to-last byte is in, not last a single cycle.
      config_complete_oe <= !(state == st_tail || state == st_delay ||
                              state == st_start || state == st_user ||
                              (state == st_load && byte_cnt >= EARLY_BYTE) ||
                              (take_byte && byte_cnt == EARLY_BYTE - 1'b1));
      init_complete_oe <= !(state == st_user);
      // pass the enable down the chain
      chip_enable_out_n <= !(state == st_tail || state == st_delay ||
                             state == st_start || state == st_user);
      user_mode <= state == st_user;
      weak_pullup_en <= state != st_user;
      data0_oe <= state == st_user && data0_user_en;
      data0_out <= data0_user_value;
    end
  end

  assign config_status_n_out = 1'b0;
  assign config_complete_out = 1'b0;
  assign init_complete_out = 1'b0;

  fpcl_fifo #(
    .W(`FPCL_DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) fpcl_fifo_i (
    .clk(clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .flush(state == st_por),
    .in_valid(take_byte),
    .in_ready(fifo_ready),
    .in_data(sync2.data),
    .out_valid(stream_valid),
    .out_ready(stream_ready),
    .out_data(stream_data)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_status_por_low: assert property (
    (clk_en && state == st_por) |=> config_status_n_oe)
    else $error("Status line not held low in power-on delay");
  a_byte_capture: assert property (
    (take_byte && fifo_ready) |=> byte_cnt == $past(byte_cnt) + 1'b1)
    else $error("Captured byte not counted");
  a_complete_early: assert property (
    (take_byte && state == st_load && byte_cnt == EARLY_BYTE - 1'b1) |=> !config_complete_oe)
    else $error("Complete line not released one byte early");
  a_complete_held: assert property (
    (clk_en && state == st_load && byte_cnt < EARLY_BYTE - 1'b1 && !take_byte)
    |=> config_complete_oe)
    else $error("Complete line released before stream accepted");
  a_chain_handover: assert property (
    (clk_en && state == st_load) ##1 (clk_en && state == st_tail) |=> !chip_enable_out_n)
    else $error("Chip enable out late after last byte");
  a_user_clock_idle: assert property (
    (clk_en && state == st_load && uclk_rise) |=> start_cnt == '0)
    else $error("User clock moved the start-up count while loading");
  a_user_release: assert property (
    (clk_en && state == st_user) |=> (!init_complete_oe && user_mode && !weak_pullup_en))
    else $error("User mode outputs wrong");
  a_data0_tristate: assert property (
    (clk_en && !data0_user_en) |=> !data0_oe)
    else $error("Data bit zero driven without option");
  a_error_pulls: assert property (
    (clk_en && take_byte && !fifo_ready) |=> ##1 config_status_n_oe)
    else $error("Own error did not pull status low");
  a_reconfig: assert property (
    (clk_en && state == st_user && !sync2.request_n) |=> state == st_por)
    else $error("Request low in user mode did not restart");

  c_user_entered: cover property (clk_en && state == st_start ##1 state == st_user);
  c_error_halt: cover property (state == st_halt && config_status_n_oe);
  c_reconfig: cover property (state == st_user ##1 state == st_por);
  c_init_seen: cover property (user_mode && init_complete_in);
endmodule : fpcl_top
`default_nettype wire

// [verif/fpcl_host.sv]
// Host model that clocks configuration bytes into the port.
`timescale 1ns/1ps
`default_nettype none
module fpcl_host (
  input wire logic clk, // Bench clock that times the link.
  input wire logic complete_line, // Shared complete line level.
  output logic config_clock, // Link clock towards the device.
  output logic [7:0] config_data // Byte bus towards the device.
);
  initial begin
    config_clock = 1'b0;
    config_data = 8'h00;
  end

  // one byte per clock
  // Each phase lasts five bench cycles, an 80 ns link period.
  task automatic send_byte(input logic [7:0] b);
    @(negedge clk);
    config_data = b;
    repeat (4) @(negedge clk);
    config_clock = 1'b1;
    repeat (5) @(negedge clk);
    config_clock = 1'b0;
    // The hold time is zero, so the old byte must not linger on the bus.
    config_data = ~b;
  endtask : send_byte

  task automatic finish(input int limit);
    int n;
    n = 0;
    while (complete_line !== 1'b1 && n < limit) begin
      send_byte(8'hA5);
      n++;
    end
    repeat (2) send_byte(8'h5A);
    @(negedge clk);
    config_data = 8'h00;
  endtask : finish
endmodule : fpcl_host
`default_nettype wire

// [verif/test_fast_parallel_config_port.sv]
// Self-checking bench of the byte-wide configuration port.
`timescale 1ns/1ps
`default_nettype none
`define TB_CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, (a), (b)); end end
module test_fast_parallel_config_port;
  import fpcl_pkg::*;
  localparam int POR = 20;
  localparam int STREAM = 12;
  localparam int FIFO = 8;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  logic config_request_n = 1'b1;
  logic config_clock;
  logic [7:0] config_data;
  logic chip_enable_in_n = 1'b0;
  logic user_clk = 1'b0;
  logic use_user_clock = 1'b0;
  logic data0_user_en = 1'b0;
  logic data0_user_value = 1'b0;
  logic load_error = 1'b0;
  logic stream_ready = 1'b0;
  logic rdy_en = 1'b0;
  logic other_hold = 1'b0;
  logic status_oe, complete_oe, init_oe, chip_enable_out_n, stream_valid;
  logic data0_out, data0_oe, user_mode, weak_pullup_en;
  logic [7:0] stream_data;
  logic [7:0] e;
  logic [7:0] exp_q[$];
  logic status_line, complete_line, init_line;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;

  // Open-drain lines with pull-ups; other_hold stands for a slower chain member.
  assign status_line = ~status_oe;
  assign complete_line = ~(complete_oe | other_hold);
  assign init_line = ~init_oe;

  fpcl_top #(.POR_CYCLES(POR), .STREAM_BYTES(STREAM), .FIFO_DEPTH(FIFO)) fpcl_top_i (
    .clk(clk), .nrst(nrst), .clk_en(clk_en), .config_request_n(config_request_n),
    .config_clock(config_clock), .config_data(config_data),
    .chip_enable_in_n(chip_enable_in_n), .user_startup_clock(user_clk),
    .use_user_clock(use_user_clock), .data0_user_en(data0_user_en),
    .data0_user_value(data0_user_value), .load_error(load_error),
    .config_status_n_in(status_line), .config_status_n_out(), .config_status_n_oe(status_oe),
    .config_complete_in(complete_line), .config_complete_out(),
    .config_complete_oe(complete_oe), .init_complete_in(init_line), .init_complete_out(),
    .init_complete_oe(init_oe), .chip_enable_out_n(chip_enable_out_n),
    .stream_data(stream_data), .stream_valid(stream_valid), .stream_ready(stream_ready),
    .data0_out(data0_out), .data0_oe(data0_oe), .user_mode(user_mode),
    .weak_pullup_en(weak_pullup_en)
  );

  fpcl_host fpcl_host_i (
    .clk(clk), .complete_line(complete_line), .config_clock(config_clock),
    .config_data(config_data)
  );

  always #4 clk = ~clk;
  always #24 user_clk = ~user_clk;
  always @(posedge clk) cyc <= cyc + 1;
  always @(negedge clk) stream_ready <= rdy_en & ($urandom_range(0, 3) != 0);

  always @(posedge clk) begin
    if (clk_en === 1'b1 && stream_valid === 1'b1 && stream_ready === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
      `TB_CHK(stream_data, e)
    end
  end

  task automatic end_of_test();
    if (fails == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  task automatic start_run();
    int n;
    config_request_n = 1'b0;
    repeat (8) @(negedge clk);
    `TB_CHK({status_oe, user_mode, complete_oe, weak_pullup_en}, 4'hB)
    config_request_n = 1'b1;
    n = 8;
    while (status_line !== 1'b1 && n < POR + 60) begin
      @(negedge clk);
      n++;
    end
    `TB_CHK(n >= POR && status_line === 1'b1, 1'b1)
    repeat (3) @(negedge clk);
  endtask : start_run

  task automatic load_and_start(input logic uclk_mode, input int hold);
    int i, n, lo, t0;
    logic [7:0] b;
    use_user_clock = uclk_mode;
    other_hold = 1'b1;
    rdy_en = 1'b1;
    for (i = 0; i < STREAM; i++) begin
      b = 8'($urandom());
      exp_q.push_back(b);
      fpcl_host_i.send_byte(b);
      if (i == 4) begin
        clk_en = 1'b0;
        repeat (100) @(negedge clk);
        `TB_CHK({complete_oe, chip_enable_out_n, user_mode}, 3'b110)
        clk_en = 1'b1;
        repeat (200) @(negedge clk);
      end
      if (i == STREAM - 3) `TB_CHK(complete_oe, 1'b1)
      if (i == STREAM - 2) `TB_CHK(complete_oe, 1'b0)
    end
    `TB_CHK(chip_enable_out_n, 1'b0)
    fork
      fpcl_host_i.finish(hold / 10 + 8);
      begin
        repeat (hold) @(negedge clk);
        `TB_CHK(user_mode, 1'b0)
        other_hold = 1'b0;
        t0 = cyc;
      end
    join
    lo = 8 + 3192 * (uclk_mode ? 6 : 1);
    n = 0;
    while (user_mode !== 1'b1 && n < lo + 200) begin
      @(negedge clk);
      n++;
    end
    n = cyc - t0;
    `TB_CHK(n >= lo && n <= lo + 60, 1'b1)
    repeat (2) @(negedge clk);
    `TB_CHK(init_line, 1'b1)
    `TB_CHK(weak_pullup_en, 1'b0)
    `TB_CHK(data0_oe, data0_user_en)
    if (data0_user_en) `TB_CHK(data0_out, data0_user_value)
    `TB_CHK(exp_q.size() == 0, 1'b1)
  endtask : load_and_start

  // Overfills the buffer with the loader stalled, then drains it in the halt.
  task automatic fill_error();
    int i, n;
    logic [7:0] b;
    rdy_en = 1'b0;
    for (i = 0; i <= FIFO; i++) begin
      b = 8'($urandom());
      if (i < FIFO) exp_q.push_back(b);
      fpcl_host_i.send_byte(b);
      if (i == FIFO - 1) `TB_CHK({status_oe, stream_valid}, 2'b01)
    end
    `TB_CHK(status_line, 1'b0)
    rdy_en = 1'b1;
    n = 0;
    while (stream_valid !== 1'b0 && n < 200) begin
      @(negedge clk);
      n++;
    end
    `TB_CHK({stream_valid, status_oe, user_mode}, 3'b010)
    `TB_CHK(exp_q.size() == 0, 1'b1)
  endtask : fill_error

  initial begin
    void'($urandom(79));
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    `TB_CHK({status_oe, complete_oe, init_oe, chip_enable_out_n, user_mode,
      weak_pullup_en, data0_oe, stream_valid}, 8'hF4)
    start_run();
    load_and_start(1'b0, 200);
    start_run();
    fill_error();
    start_run();
    data0_user_en = 1'b1;
    data0_user_value = 1'($urandom());
    load_and_start(1'b1, 0);
    end_of_test();
  end

  // The whole run needs about 24000 cycles; this leaves a wide margin.
  initial begin
    #400us;
    fails++;
    end_of_test();
  end
endmodule : test_fast_parallel_config_port
`undef TB_CHK
`default_nettype wire
